// *** src/fsr_regs.sv ***
/*
 * Status and configuration register bank of a quad-SPI nonvolatile memory:
 * block protection, write enable latch, CRC busy/suspend/abort, and the first
 * configuration register with its volatile copy.
 * Assumes a command decoder on the serial clock that presents one whole
 * command per chip-select frame, an external nonvolatile store for the
 * configuration image, and memory/read-data consumers on ref_clk_in.
 */
`timescale 1ns/1ns
`include "fsr_defs.svh"
module fsr_regs (
	input wire logic ref_clk_in, // Core clock, 100 MHz
	input wire logic rst_b_in, // Power-on reset, async, active low
	input wire logic ce_in, // Core clock enable, freezes core state
	input wire logic lnk_clk_in, // Serial link clock
	input wire logic lnk_cmd_valid_in, // Command complete, link domain pulse
	input wire fsr_pkg::fsr_cmd_s lnk_cmd_in, // Decoded command, link domain
	output logic lnk_ready_out, // Link may hand over a command
	input wire logic wp_b_in, // Write-protect pin, active low
	input wire logic hw_rst_b_in, // Hardware reset pin, active low
	input wire logic [7:0] nv_cfg1_in, // Stored nonvolatile config image
	output logic nv_cfg1_wr_out, // Pulse: store nv_cfg1_data_out
	output logic [7:0] nv_cfg1_data_out, // New nonvolatile config image
	output logic rd_valid_out, // Pulse: register read data valid
	output logic [7:0] rd_data_out, // Register read data
	output logic mem_wr_go_out, // Pulse: memory byte write granted
	output logic [17:0] mem_wr_addr_out, // Granted write address
	output logic [7:0] mem_wr_data_out, // Granted write data
	output logic [3:0] latency_code_out, // Dummy cycles for reads
	output logic quad_enable_out, // Quad I/O for extended access
	output logic busy_out // CRC calculation running
);
	import fsr_pkg::*;

	// Link domain state
	fsr_cmd_s hold_q;
	logic req_tog_q;
	logic ack_s1_q;
	logic ack_s2_q;
	logic lnk_ready_q;

	// Core domain crossing and pins
	logic req_s1_q;
	logic req_s2_q;
	logic req_s3_q;
	logic ack_tog_q;
	logic wp_s1_q;
	logic wp_s2_q;
	logic hw_s1_q;
	logic hw_s2_q;
	logic boot_q;

	// Registers
	logic latch_q;
	logic lock_q;
	logic origin_q;
	logic [2:0] bp_q;
	logic [7:0] cfg1_q;
	logic susp_q;
	logic abort_q;
	logic arm_q;
	fsr_crc_e crc_q;
	logic busy_q;
	logic [23:0] crc_ptr_q;
	logic [23:0] crc_end_q;

	// Output flops
	logic nv_wr_q;
	logic [7:0] nv_data_q;
	logic rd_valid_q;
	logic [7:0] rd_data_q;
	logic mem_go_q;
	logic [17:0] mem_addr_q;
	logic [7:0] mem_data_q;

	// Decode nets
	logic fire;
	logic accept;
	logic [7:0] op;
	logic soft_rst;
	logic hw_rst;
	logic rst_vol;
	logic reg_wr_ok;
	logic [7:0] stat1_val;
	logic [7:0] stat2_val;

	// Commands still served while the CRC engine runs
	function automatic logic busy_allowed(input logic [7:0] code);
		busy_allowed = (code == `FSR_OP_STAT1_READ) || (code == `FSR_OP_STAT2_READ) ||
			(code == `FSR_OP_GEN_READ) || (code == `FSR_OP_CRC_SUSPEND) ||
			(code == `FSR_OP_RESET_ARM) || (code == `FSR_OP_RESET_GO);
	endfunction

	// Address falls in the protected block range
	function automatic logic prot_hit(input logic [17:0] a, input logic [2:0] bp, input logic from_bottom);
		logic [17:0] mask;
		logic [4:0] sh;
		mask = '0;
		sh = 5'(`FSR_PROT_SHIFT_BASE) + 5'(bp);
		mask = 18'(18'h3FFFF << sh);
		if (bp == 3'h0) begin
			prot_hit = 1'b0;
		end else if (from_bottom) begin
			prot_hit = ((a & mask) == 18'h00000);
		end else begin
			prot_hit = ((a & mask) == mask);
		end
	endfunction

	// Link side: capture a command and toggle the request
	always_ff @(posedge lnk_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			hold_q <= '0;
			req_tog_q <= 1'b0;
			lnk_ready_q <= 1'b1;
		end else if (lnk_cmd_valid_in && lnk_ready_q) begin
			hold_q <= lnk_cmd_in;
			req_tog_q <= ~req_tog_q;
			lnk_ready_q <= 1'b0;
		end else begin
			lnk_ready_q <= (req_tog_q == ack_s2_q);
		end
	end

	// Link side: acknowledge toggle synchroniser
	always_ff @(posedge lnk_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ack_tog_q;
			ack_s2_q <= ack_s1_q;
		end
	end

	assign lnk_ready_out = lnk_ready_q;

	// Core side: request toggle and pin synchronisers
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			req_s3_q <= 1'b0;
			wp_s1_q <= 1'b1;
			wp_s2_q <= 1'b1;
			hw_s1_q <= 1'b1;
			hw_s2_q <= 1'b1;
		end else if (ce_in) begin
			req_s1_q <= req_tog_q;
			req_s2_q <= req_s1_q;
			req_s3_q <= req_s2_q;
			wp_s1_q <= wp_b_in;
			wp_s2_q <= wp_s1_q;
			hw_s1_q <= hw_rst_b_in;
			hw_s2_q <= hw_s1_q;
		end
	end

	// Command arrival; hold_q is stable until the acknowledge returns
	assign fire = req_s2_q ^ req_s3_q;
	assign op = hold_q.opcode;
	assign accept = fire && (!busy_q || busy_allowed(op));
	assign soft_rst = accept && arm_q && (op == `FSR_OP_RESET_GO);
	assign hw_rst = !hw_s2_q;
	assign rst_vol = soft_rst || hw_rst;
	assign reg_wr_ok = latch_q && !(lock_q && !wp_s2_q);

	// Read images; reserved bits are zero
	assign stat1_val = {lock_q, 1'b0, origin_q, bp_q, latch_q, busy_q};
	assign stat2_val = {3'b000, susp_q, abort_q, 3'b000};

	// Acknowledge toggle back to the link
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ack_tog_q <= 1'b0;
		end else if (ce_in && fire) begin
			ack_tog_q <= req_s2_q;
		end
	end

	// Reset-arm step of the software reset pair
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			arm_q <= 1'b0;
		end else if (ce_in && accept) begin
			arm_q <= (op == `FSR_OP_RESET_ARM);
		end
	end

	// Write enable latch
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			latch_q <= 1'b0;
		end else if (ce_in) begin
			if (rst_vol) begin
				latch_q <= 1'b0;
			end else if (accept) begin
				unique case (op)
					`FSR_OP_WR_ENABLE: latch_q <= 1'b1;
					`FSR_OP_WR_DISABLE, `FSR_OP_STAT_WRITE, `FSR_OP_SPECIAL_WRITE,
					`FSR_OP_GEN_WRITE, `FSR_OP_SERIAL_WRITE: latch_q <= 1'b0;
					default: latch_q <= latch_q;
				endcase
			end
		end
	end

	// Protection and lock bits of the first status register
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			lock_q <= 1'b0;
			origin_q <= 1'b0;
			bp_q <= 3'h0;
		end else if (ce_in) begin
			if (rst_vol) begin
				lock_q <= 1'b0;
				origin_q <= 1'b0;
				bp_q <= 3'h0;
			end else if (accept && reg_wr_ok && (op == `FSR_OP_STAT_WRITE)) begin
				// Latch and busy bits are read-only; busy is untouched and the latch is cleared
				lock_q <= hold_q.data[`FSR_STAT1_LOCK_BIT];
				origin_q <= hold_q.data[`FSR_STAT1_ORIGIN_BIT];
				bp_q <= hold_q.data[`FSR_STAT1_BP_HI:`FSR_STAT1_BP_LO];
			end
		end
	end

	// Volatile configuration copy and nonvolatile update request
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			cfg1_q <= `FSR_CFG1_RESET;
			boot_q <= 1'b1;
			nv_wr_q <= 1'b0;
			nv_data_q <= `FSR_CFG1_RESET;
		end else if (ce_in) begin
			nv_wr_q <= 1'b0;
			boot_q <= 1'b0;
			if (boot_q || hw_rst) begin
				cfg1_q <= nv_cfg1_in & `FSR_CFG1_WMASK;
			end else if (accept && reg_wr_ok && (op == `FSR_OP_GEN_WRITE)) begin
				if (hold_q.addr == `FSR_ADDR_CFG1_NV) begin
					cfg1_q <= hold_q.data & `FSR_CFG1_WMASK;
					nv_wr_q <= 1'b1;
					nv_data_q <= hold_q.data & `FSR_CFG1_WMASK;
				end else if (hold_q.addr == `FSR_ADDR_CFG1_V) begin
					cfg1_q <= hold_q.data & `FSR_CFG1_WMASK;
				end
			end
		end
	end

	// CRC engine: busy, suspend and abort
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			crc_q <= FSR_CRC_IDLE;
			busy_q <= 1'b0;
			susp_q <= 1'b0;
			abort_q <= 1'b0;
			crc_ptr_q <= 24'h000000;
			crc_end_q <= 24'h000000;
		end else if (ce_in) begin
			if (rst_vol) begin
				crc_q <= FSR_CRC_IDLE;
				busy_q <= 1'b0;
				susp_q <= 1'b0;
				abort_q <= 1'b0;
			end else begin
				unique case (crc_q)
					FSR_CRC_IDLE: begin
						if (accept && (op == `FSR_OP_CRC_COMPUTE)) begin
							if ({1'b0, hold_q.end_addr} < ({1'b0, hold_q.addr} + `FSR_CRC_MIN_SPAN)) begin
								abort_q <= 1'b1;
							end else begin
								abort_q <= 1'b0;
								crc_ptr_q <= hold_q.addr;
								crc_end_q <= hold_q.end_addr;
								crc_q <= FSR_CRC_RUN;
								busy_q <= 1'b1;
							end
						end
					end
					FSR_CRC_RUN: begin
						if (accept && (op == `FSR_OP_CRC_SUSPEND)) begin
							susp_q <= 1'b1;
							crc_q <= FSR_CRC_SUSP;
							busy_q <= 1'b0;
						end else if (crc_ptr_q == crc_end_q) begin
							crc_q <= FSR_CRC_IDLE;
							busy_q <= 1'b0;
						end else begin
							crc_ptr_q <= crc_ptr_q + 24'h000001;
						end
					end
					FSR_CRC_SUSP: begin
						if (accept && (op == `FSR_OP_CRC_RESUME)) begin
							susp_q <= 1'b0;
							crc_q <= FSR_CRC_RUN;
							busy_q <= 1'b1;
						end
					end
					default: begin
						crc_q <= FSR_CRC_IDLE;
						busy_q <= 1'b0;
					end
				endcase
			end
		end
	end

	// Register reads always show the volatile copy
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rd_valid_q <= 1'b0;
			rd_data_q <= `FSR_BYTE_ZERO;
		end else if (ce_in) begin
			rd_valid_q <= 1'b0;
			if (accept && !soft_rst) begin
				unique case (op)
					`FSR_OP_STAT1_READ: begin
						rd_valid_q <= 1'b1;
						rd_data_q <= stat1_val;
					end
					`FSR_OP_STAT2_READ: begin
						rd_valid_q <= 1'b1;
						rd_data_q <= stat2_val;
					end
					`FSR_OP_CFG1_READ: begin
						rd_valid_q <= 1'b1;
						rd_data_q <= cfg1_q;
					end
					`FSR_OP_GEN_READ: begin
						rd_valid_q <= 1'b1;
						unique case (hold_q.addr)
							`FSR_ADDR_STAT1_NV, `FSR_ADDR_STAT1_V: rd_data_q <= stat1_val;
							`FSR_ADDR_STAT2_NV, `FSR_ADDR_STAT2_V: rd_data_q <= stat2_val;
							`FSR_ADDR_CFG1_NV, `FSR_ADDR_CFG1_V: rd_data_q <= cfg1_q;
							default: rd_data_q <= `FSR_BYTE_ZERO;
						endcase
					end
					default: rd_valid_q <= 1'b0;
				endcase
			end
		end
	end

	// Memory write grant: latch set and outside the protected range
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mem_go_q <= 1'b0;
			mem_addr_q <= 18'h00000;
			mem_data_q <= `FSR_BYTE_ZERO;
		end else if (ce_in) begin
			mem_go_q <= 1'b0;
			if (accept && (op == `FSR_OP_MEM_WRITE) && latch_q &&
				!prot_hit(hold_q.addr[17:0], bp_q, origin_q)) begin
				mem_go_q <= 1'b1;
				mem_addr_q <= hold_q.addr[17:0];
				mem_data_q <= hold_q.data;
			end
		end
	end

	// Outputs, all from flops
	assign nv_cfg1_wr_out = nv_wr_q;
	assign nv_cfg1_data_out = nv_data_q;
	assign rd_valid_out = rd_valid_q;
	assign rd_data_out = rd_data_q;
	assign mem_wr_go_out = mem_go_q;
	assign mem_wr_addr_out = mem_addr_q;
	assign mem_wr_data_out = mem_data_q;
	assign latency_code_out = cfg1_q[`FSR_CFG1_LAT_HI:`FSR_CFG1_LAT_LO];
	assign quad_enable_out = cfg1_q[`FSR_CFG1_QUAD_BIT];
	assign busy_out = busy_q;
endmodule

// *** src/fsr_defs.svh ***
/*
 * Constants of the status and configuration register bank: opcodes, register
 * addresses, field positions, write masks, reset values and CRC limits.
 * Assumes it is included by its bare name from the package and the design.
 */
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// Command opcodes
`define FSR_OP_WR_ENABLE 8'h06
`define FSR_OP_WR_DISABLE 8'h04
`define FSR_OP_STAT_WRITE 8'h01
`define FSR_OP_SPECIAL_WRITE 8'h42
`define FSR_OP_GEN_WRITE 8'h71
`define FSR_OP_SERIAL_WRITE 8'hC2
`define FSR_OP_MEM_WRITE 8'h02
`define FSR_OP_STAT1_READ 8'h05
`define FSR_OP_STAT2_READ 8'h07
`define FSR_OP_CFG1_READ 8'h35
`define FSR_OP_GEN_READ 8'h65
`define FSR_OP_CRC_COMPUTE 8'h5B
`define FSR_OP_CRC_SUSPEND 8'h75
`define FSR_OP_CRC_RESUME 8'h7A
`define FSR_OP_RESET_ARM 8'h66
`define FSR_OP_RESET_GO 8'h99

// Generic register addresses
`define FSR_ADDR_STAT1_NV 24'h000000
`define FSR_ADDR_STAT1_V 24'h070000
`define FSR_ADDR_STAT2_NV 24'h000001
`define FSR_ADDR_STAT2_V 24'h070001
`define FSR_ADDR_CFG1_NV 24'h000002
`define FSR_ADDR_CFG1_V 24'h070002

// Field positions
`define FSR_STAT1_LOCK_BIT 7
`define FSR_STAT1_ORIGIN_BIT 5
`define FSR_STAT1_BP_HI 4
`define FSR_STAT1_BP_LO 2
`define FSR_STAT1_LATCH_BIT 1
`define FSR_STAT1_BUSY_BIT 0
`define FSR_STAT2_SUSP_BIT 4
`define FSR_STAT2_ABORT_BIT 3
`define FSR_CFG1_LAT_HI 7
`define FSR_CFG1_LAT_LO 4
`define FSR_CFG1_QUAD_BIT 1

// Writable bits and reset values
`define FSR_STAT1_WMASK 8'hBC
`define FSR_CFG1_WMASK 8'hF2
`define FSR_STAT1_RESET 8'h00
`define FSR_CFG1_RESET 8'h00
`define FSR_BYTE_ZERO 8'h00

// Array and CRC figures
`define FSR_ARRAY_BITS 18
`define FSR_PROT_SHIFT_BASE 11
`define FSR_CRC_MIN_SPAN 25'h0000003

`endif

// *** src/fsr_pkg.sv ***
/*
 * Types of the status and configuration register bank.
 * Assumes fsr_defs.svh is on the include path.
 */
package fsr_pkg;
	`include "fsr_defs.svh"

	// One decoded command, handed over at chip-select rising
	typedef struct packed {
		logic [7:0] opcode;
		logic [23:0] addr;
		logic [23:0] end_addr;
		logic [7:0] data;
	} fsr_cmd_s;

	// CRC engine states
	typedef enum logic [1:0] {
		FSR_CRC_IDLE = 2'b00,
		FSR_CRC_RUN = 2'b01,
		FSR_CRC_SUSP = 2'b10
	} fsr_crc_e;
endpackage

// *** verification/fsr_regs_props.sv ***
/*
 * Port checker for the status and configuration register bank.
 * Assumes it is bound to fsr_regs and sees only its ports.
 */
`timescale 1ns/1ns
module fsr_regs_props (
	input wire logic ref_clk_in, // Core clock
	input wire logic rst_b_in, // Power-on reset
	input wire logic ce_in, // Core enable
	input wire logic lnk_clk_in, // Link clock
	input wire logic lnk_cmd_valid_in, // Command offered
	input wire logic lnk_ready_out, // Link ready
	input wire logic hw_rst_b_in, // Hardware reset pin
	input wire logic [7:0] nv_cfg1_in, // Stored image
	input wire logic nv_cfg1_wr_out, // Store pulse
	input wire logic [7:0] nv_cfg1_data_out, // New image
	input wire logic rd_valid_out, // Read pulse
	input wire logic mem_wr_go_out, // Write grant
	input wire logic [3:0] latency_code_out, // Dummy cycles
	input wire logic quad_enable_out, // Quad select
	input wire logic busy_out // CRC busy
);
	// Relations between core inputs and outputs
	property p_nv_mask;
		@(posedge ref_clk_in) disable iff (!rst_b_in) nv_cfg1_wr_out |-> (nv_cfg1_data_out & 8'h0D) == 8'h00;
	endproperty
	a_nv_mask: assert property (p_nv_mask) else $error("reserved bits in stored image");
	property p_nv_both;
		@(posedge ref_clk_in) disable iff (!rst_b_in)
			nv_cfg1_wr_out |-> latency_code_out == nv_cfg1_data_out[7:4] && quad_enable_out == nv_cfg1_data_out[1];
	endproperty
	a_nv_both: assert property (p_nv_both) else $error("volatile copy misses stored write");
	property p_rd_pulse;
		@(posedge ref_clk_in) disable iff (!rst_b_in) rd_valid_out |=> !rd_valid_out;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read valid longer than one cycle");
	property p_mem_pulse;
		@(posedge ref_clk_in) disable iff (!rst_b_in) mem_wr_go_out |=> !mem_wr_go_out;
	endproperty
	a_mem_pulse: assert property (p_mem_pulse) else $error("write grant longer than one cycle");
	property p_busy_quiet;
		@(posedge ref_clk_in) disable iff (!rst_b_in) busy_out |-> !mem_wr_go_out && !nv_cfg1_wr_out;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("write done while busy");
	property p_hw_busy;
		@(posedge ref_clk_in) disable iff (!rst_b_in) (!hw_rst_b_in && ce_in) [*4] |=> !busy_out;
	endproperty
	a_hw_busy: assert property (p_hw_busy) else $error("busy kept over hardware reset");
	property p_hw_load;
		@(posedge ref_clk_in) disable iff (!rst_b_in) (!hw_rst_b_in && ce_in) [*4] |=>
			latency_code_out == nv_cfg1_in[7:4] && quad_enable_out == nv_cfg1_in[1];
	endproperty
	a_hw_load: assert property (p_hw_load) else $error("config not reloaded on hardware reset");
	// Link side handshake
	property p_ready_drop;
		@(posedge lnk_clk_in) disable iff (!rst_b_in) lnk_cmd_valid_in && lnk_ready_out |=> !lnk_ready_out;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("ready kept after command taken");
endmodule

bind fsr_regs fsr_regs_props chk_i (.ref_clk_in, .rst_b_in, .ce_in, .lnk_clk_in, .lnk_cmd_valid_in,
	.lnk_ready_out, .hw_rst_b_in, .nv_cfg1_in, .nv_cfg1_wr_out, .nv_cfg1_data_out, .rd_valid_out,
	.mem_wr_go_out, .latency_code_out, .quad_enable_out, .busy_out);

// *** verification/fsr_host.sv ***
/*
 * Link-side host model: offers one decoded command per frame.
 * Assumes the bank answers with lnk_ready_out on the link clock.
 */
`timescale 1ns/1ns
module fsr_host (
	output logic lnk_clk_out, // Link clock, 12 ns, parked low
	output logic lnk_cmd_valid_out, // Command offered
	output fsr_pkg::fsr_cmd_s lnk_cmd_out, // Command body
	input wire logic lnk_ready_in // Bank can take a command
);
	import fsr_pkg::*;
	logic run;
	// Clock runs only within a frame; even offset keeps it off core rising edges
	initial begin
		lnk_clk_out = 1'b0;
		run = 1'b0;
		lnk_cmd_valid_out = 1'b0;
		lnk_cmd_out = '0;
		#2;
		forever begin
			#6;
			if (run || lnk_clk_out) lnk_clk_out = ~lnk_clk_out;
		end
	end
	// Hold the command until taken, then run on until ready returns
	task automatic send(input fsr_cmd_s c);
		int n;
		run = 1'b1;
		@(negedge lnk_clk_out);
		lnk_cmd_out = c;
		lnk_cmd_valid_out = 1'b1;
		for (n = 0; n < 50 && lnk_ready_in !== 1'b1; n++) @(negedge lnk_clk_out);
		@(negedge lnk_clk_out);
		lnk_cmd_valid_out = 1'b0;
		lnk_cmd_out = ~c;
		for (n = 0; n < 200 && lnk_ready_in !== 1'b1; n++) @(negedge lnk_clk_out);
		run = 1'b0;
	endtask
endmodule

// *** verification/test_fsr_regs.sv ***
/*
 * Self-checking bench of the register bank with a host model and NV store.
 * Assumes fsr_pkg, fsr_host and the bound checker are compiled first.
 */
`timescale 1ns/1ns
module test_fsr_regs;
	import fsr_pkg::*;
	logic ref_clk_in, rst_b_in, ce_in, wp_b_in, hw_rst_b_in, lnk_clk_in, lnk_cmd_valid_in, lnk_ready_out;
	logic nv_cfg1_wr_out, rd_valid_out, mem_wr_go_out, quad_enable_out, busy_out;
	logic [7:0] nv_q, nv_cfg1_data_out, rd_data_out, mem_wr_data_out, last_rd;
	logic [17:0] mem_wr_addr_out;
	logic [3:0] latency_code_out;
	fsr_cmd_s lnk_cmd_in;
	wire [7:0] nv_cfg1_in = nv_q;
	int n_fail, n_checks, mem_n;
	fsr_regs uut (.ref_clk_in, .rst_b_in, .ce_in, .lnk_clk_in, .lnk_cmd_valid_in, .lnk_cmd_in, .lnk_ready_out,
		.wp_b_in, .hw_rst_b_in, .nv_cfg1_in, .nv_cfg1_wr_out, .nv_cfg1_data_out, .rd_valid_out, .rd_data_out,
		.mem_wr_go_out, .mem_wr_addr_out, .mem_wr_data_out, .latency_code_out, .quad_enable_out, .busy_out);
	fsr_host host (.lnk_clk_out(lnk_clk_in), .lnk_cmd_valid_out(lnk_cmd_valid_in), .lnk_cmd_out(lnk_cmd_in),
		.lnk_ready_in(lnk_ready_out));
	// Core clock
	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	// Catch read data, count grants, keep the NV image; mid-cycle, off the launch edge
	always @(negedge ref_clk_in) begin
		if (rd_valid_out === 1'b1) last_rd <= rd_data_out;
		if (mem_wr_go_out === 1'b1) mem_n <= mem_n + 1;
		if (nv_cfg1_wr_out === 1'b1) nv_q <= nv_cfg1_data_out;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [7:0] op, input logic [23:0] a = 24'h000000, input logic [7:0] d = 8'h00,
		input logic [23:0] e = 24'h000000);
		host.send({op, a, e, d});
		repeat (4) @(negedge ref_clk_in);
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] exp);
		last_rd = 8'hXX;
		cmd(op, a);
		chk(last_rd, exp);
	endtask
	task automatic mem(input logic [23:0] a, input int go);
		int n0;
		n0 = mem_n;
		cmd(8'h02, a, 8'hA5);
		chk(mem_n - n0, go);
		if (go == 1) chk(mem_wr_addr_out, a[17:0]);
		if (go == 1) chk(mem_wr_data_out, 8'hA5);
	endtask
	task automatic t_boot();
		rd(8'h05, 24'h000000, 8'h00);
		rd(8'h07, 24'h000000, 8'h00);
		rd(8'h65, 24'h070001, 8'h00);
		rd(8'h35, 24'h000000, 8'hF2);
		chk(latency_code_out, 4'hF);
		$display("t_boot done");
	endtask
	task automatic t_latch();
		logic [7:0] ops [5] = '{8'h04, 8'h01, 8'h42, 8'h71, 8'hC2};
		mem(24'h000100, 0);
		cmd(8'h06);
		rd(8'h05, 24'h000000, 8'h02);
		mem(24'h000100, 1);
		mem(24'h000101, 1);
		foreach (ops[i]) begin
			cmd(8'h06);
			cmd(ops[i], 24'h070001, 8'h00);
			rd(8'h05, 24'h000000, 8'h00);
		end
		cmd(8'h06);
		cmd(8'h71, 24'h070001, 8'hFF);
		rd(8'h07, 24'h000000, 8'h00);
		$display("t_latch done");
	endtask
	task automatic t_protect();
		logic [18:0] sz, in_a;
		for (int o = 0; o < 2; o++) begin
			for (int b = 1; b < 8; b++) begin
				sz = 19'h00800 << b;
				in_a = o ? sz - 19'h00001 : 19'h40000 - sz;
				cmd(8'h06);
				cmd(8'h01, 24'h000000, {2'b00, o[0], b[2:0], 2'b00});
				cmd(8'h06);
				mem({5'h00, in_a}, 0);
				if (b < 7) mem({5'h00, o ? in_a + 19'h00001 : in_a - 19'h00001}, 1);
			end
		end
		cmd(8'h06);
		cmd(8'h01, 24'h000000, 8'h00);
		$display("t_protect done");
	endtask
	task automatic t_lock();
		cmd(8'h06);
		cmd(8'h01, 24'h000000, 8'h80);
		wp_b_in = 1'b0;
		repeat (3) @(negedge ref_clk_in);
		cmd(8'h06);
		cmd(8'h01, 24'h000000, 8'h84);
		rd(8'h05, 24'h000000, 8'h80);
		cmd(8'h06);
		cmd(8'h71, 24'h070002, 8'h10);
		rd(8'h35, 24'h000000, 8'hF2);
		wp_b_in = 1'b1;
		repeat (3) @(negedge ref_clk_in);
		cmd(8'h06);
		cmd(8'h01, 24'h000000, 8'h00);
		rd(8'h05, 24'h000000, 8'h00);
		$display("t_lock done");
	endtask
	task automatic t_cfg();
		cmd(8'h06);
		cmd(8'h71, 24'h070002, 8'h6F);
		rd(8'h35, 24'h000000, 8'h62);
		chk(latency_code_out, 4'h6);
		chk(quad_enable_out, 1'b1);
		chk(nv_q, 8'hFF);
		cmd(8'h06);
		cmd(8'h71, 24'h000002, 8'hA0);
		chk(nv_q, 8'hA0);
		rd(8'h65, 24'h000002, 8'hA0);
		cmd(8'h06);
		cmd(8'h71, 24'h070002, 8'h12);
		rd(8'h65, 24'h070002, 8'h12);
		cmd(8'h06);
		hw_rst_b_in = 1'b0;
		repeat (5) @(negedge ref_clk_in);
		hw_rst_b_in = 1'b1;
		// Fixed wait, busy is not polled
		repeat (5) @(negedge ref_clk_in);
		rd(8'h35, 24'h000000, 8'hA0);
		chk(quad_enable_out, 1'b0);
		rd(8'h05, 24'h000000, 8'h00);
		$display("t_cfg done");
	endtask
	task automatic t_crc();
		cmd(8'h5B, 24'h000010, 8'h00, 24'h000012);
		chk(busy_out, 1'b0);
		rd(8'h07, 24'h000000, 8'h08);
		cmd(8'h5B, 24'h000000, 8'h00, 24'h0003E7);
		chk(busy_out, 1'b1);
		cmd(8'h06);
		rd(8'h05, 24'h000000, 8'h01);
		cmd(8'h75);
		chk(busy_out, 1'b0);
		rd(8'h07, 24'h000000, 8'h10);
		cmd(8'h7A);
		chk(busy_out, 1'b1);
		rd(8'h07, 24'h000000, 8'h00);
		cmd(8'h66);
		cmd(8'h99);
		chk(busy_out, 1'b0);
		rd(8'h05, 24'h000000, 8'h00);
		cmd(8'h5B, 24'h000000, 8'h00, 24'h000031);
		chk(busy_out, 1'b1);
		// Freeze the core mid-run; the count must pause
		ce_in = 1'b0;
		repeat (60) @(negedge ref_clk_in);
		chk(busy_out, 1'b1);
		ce_in = 1'b1;
		repeat (60) @(negedge ref_clk_in);
		chk(busy_out, 1'b0);
		$display("t_crc done");
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_b_in = 1'b0;
		ce_in = 1'b1;
		wp_b_in = 1'b1;
		hw_rst_b_in = 1'b1;
		nv_q = 8'hFF;
		last_rd = 8'h00;
		n_fail = 0;
		n_checks = 0;
		mem_n = 0;
		repeat (4) @(negedge ref_clk_in);
		rst_b_in = 1'b1;
		repeat (2) @(negedge ref_clk_in);
		t_boot();
		t_latch();
		t_protect();
		t_lock();
		t_cfg();
		t_crc();
		end_of_test();
	end
	// Watchdog
	initial begin
		#500000;
		n_fail++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_of_test();
	end
endmodule
